// file: spi_port_pkg.sv
`default_nettype none
// Shared constants for the serial peripheral port.
package spi_port_pkg;

  // Register indices; each register takes one word at four times its index.
  localparam logic [7:0]  IDX_DATA   = 8'h21;
  localparam logic [7:0]  IDX_CTRL   = 8'h22;
  localparam logic [7:0]  IDX_STAT   = 8'h23;
  localparam logic [11:0] ADDR_DATA  = {2'b00, IDX_DATA, 2'b00};
  localparam logic [11:0] ADDR_CTRL  = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT  = {2'b00, IDX_STAT, 2'b00};

  // Control register fields.
  localparam int CTL_IRQ_EN   = 7;
  localparam int CTL_PORT_EN  = 6;
  localparam int CTL_DIV2     = 5;
  localparam int CTL_MASTER   = 4;
  localparam int CTL_CLOCK_POLARITY     = 3;
  localparam int CTL_CLOCK_PHASE     = 2;
  localparam int CTL_RATE_HI  = 1;
  localparam int CTL_RATE_LO  = 0;

  // Status register fields.
  localparam int STAT_DONE    = 7;
  localparam int STAT_WRITE_COLLISION_FLAG    = 6;
  localparam int STAT_MODE_FAULT_FLAG    = 4;
  localparam int BYTE_MSB     = 7;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // Rate codes {div2_bypass, rate_select} and their clock dividers.
  localparam logic [2:0] RATE_DIV4   = 3'b100;
  localparam logic [2:0] RATE_DIV8   = 3'b000;
  localparam logic [2:0] RATE_DIV16  = 3'b001;
  localparam logic [2:0] RATE_DIV32  = 3'b110;
  localparam logic [2:0] RATE_DIV64  = 3'b010;
  localparam logic [2:0] RATE_DIV128 = 3'b011;
  localparam logic [6:0] HALF_DIV4   = 7'(4 / 2);
  localparam logic [6:0] HALF_DIV8   = 7'(8 / 2);
  localparam logic [6:0] HALF_DIV16  = 7'(16 / 2);
  localparam logic [6:0] HALF_DIV32  = 7'(32 / 2);
  localparam logic [6:0] HALF_DIV64  = 7'(64 / 2);
  localparam logic [6:0] HALF_DIV128 = 7'(128 / 2);

  // Byte framing: sixteen serial clock edges, eight captures.
  localparam logic [4:0] EDGE_LAST   = 5'h0F;
  localparam logic [2:0] CAP_LAST    = 3'h7;

  // Transfer engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} xfer_state_type;

endpackage
`default_nettype wire

// file: spi_port.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Interrupt when enabled and done or fault
// - Port enable zero releases pins to ports
// - Fault clears port enable and master select
// - Master select drives clock, swaps data pins
// - Clock polarity sets idle clock level
// - Clock phase picks first capture edge
// - Master rate from six dividers
// - Rate bits ignored in slave mode
// - Done flag set; status then data clears
// - Data writes ignored while done flag set, unless a status read came first
// - Write during transfer sets collision flag
// - Fault flag cleared by status then control
// - Status read only, unused bits zero
// - Master transfer starts only on data write
// - Received byte copied to receive buffer
// - Write loads shifter, read returns buffer
// - Divide-by-two stage bypass, reset cleared
// - Collision leaves transfer running, write dropped
// - Fault blocks enabling outside clear sequence
// - Low select freezes slave data register
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             irq
);

  // Bus registers.
  logic [31:0]    prdata_ff;     // Read data captured in the setup cycle.
  logic           pready_ff;     // High in the first access cycle.
  logic           pslverr_ff;    // Error answer for an unmapped address.
  // Software visible state.
  logic [7:0]     ctrl_ff;       // Control register.
  logic [7:0]     nxt_ctrl;
  logic           done_ff;       // Transfer done flag.
  logic           write_collision_flag_ff;       // Write collision flag.
  logic           mode_fault_flag_ff;       // Mode fault flag.
  logic           done_arm_ff;   // Status seen with done set.
  logic           write_collision_flag_arm_ff;   // Status seen with collision set.
  logic           mode_fault_flag_arm_ff;   // Status seen with fault set.
  logic [7:0]     rx_buf_ff;     // Receive buffer.
  // Transfer engine.
  xfer_state_type state_ff;
  xfer_state_type nxt_state;
  logic [7:0]     shift_ff;      // Shift register.
  logic [7:0]     nxt_shift;
  logic           out_bit_ff;    // Bit driven onto the data output.
  logic           nxt_out;
  logic [4:0]     edge_cnt_ff;   // Serial clock edges seen in this byte.
  logic [4:0]     nxt_edge;
  logic [2:0]     cap_cnt_ff;    // Capture edges seen in this byte.
  logic [2:0]     nxt_cap;
  logic [6:0]     div_cnt_ff;    // Half period counter for the master.
  logic [6:0]     nxt_div;
  logic [7:0]     nxt_rx;
  logic           sck_ff;        // Serial clock driven as master.
  logic           nxt_sck;
  logic           sck_prev_ff;   // Previous sample of the clock input.
  // Pin enables and interrupt.
  logic           sck_oe_ff;
  logic           mosi_oe_ff;
  logic           miso_oe_ff;
  logic           irq_ff;

  // Bus decode.
  wire setup     = psel & ~penable;
  wire access    = psel & penable & pready_ff;
  wire hit_data  = paddr == ADDR_DATA;
  wire hit_ctrl  = paddr == ADDR_CTRL;
  wire hit_stat  = paddr == ADDR_STAT;
  wire mapped    = hit_data | hit_ctrl | hit_stat;
  wire dr_access = access & hit_data;
  wire wr_data   = dr_access & pwrite;
  wire sr_access = access & hit_stat;
  wire cr_write  = access & hit_ctrl & pwrite;

  // Mode decode.
  wire port_en   = ctrl_ff[CTL_PORT_EN];
  wire is_master = ctrl_ff[CTL_MASTER];
  wire clock_phase      = ctrl_ff[CTL_CLOCK_PHASE];
  wire clock_polarity      = ctrl_ff[CTL_CLOCK_POLARITY];
  wire master_on = port_en & is_master;
  wire slave_sel = port_en & ~is_master & ~ss_n_in;
  wire fault_evt = is_master & ~ss_n_in;
  wire busy_now  = (state_ff != ST_IDLE) | slave_sel;
  wire write_collision_flag_evt  = wr_data & busy_now;
  // A write lands only when idle and the done flag is clear or being
  // cleared by this very access.
  wire dr_load   = wr_data & ~busy_now & (~done_ff | done_arm_ff);

  // Rate select; the code is only used while the master runs.
  wire [2:0] rate_code = {ctrl_ff[CTL_DIV2], ctrl_ff[CTL_RATE_HI],
                          ctrl_ff[CTL_RATE_LO]};
  wire [6:0] half_cnt =
    (rate_code == RATE_DIV4)   ? HALF_DIV4   :
    (rate_code == RATE_DIV16)  ? HALF_DIV16  :
    (rate_code == RATE_DIV32)  ? HALF_DIV32  :
    (rate_code == RATE_DIV64)  ? HALF_DIV64  :
    (rate_code == RATE_DIV128) ? HALF_DIV128 : HALF_DIV8;

  // Edge events; the rate bits only feed the master tick.
  wire m_tick  = (state_ff == ST_MASTER) & master_on &
                 (div_cnt_ff == half_cnt - 7'h01);
  wire s_edge  = (state_ff == ST_SLAVE) & slave_sel &
                 (sck_in != sck_prev_ff);
  wire sh_edge = m_tick | s_edge;
  wire cap_edg = sh_edge & (edge_cnt_ff[0] == clock_phase);
  wire rx_in   = is_master ? miso_in : mosi_in;
  wire [7:0] shifted = {shift_ff[6:0], rx_in};
  wire last_cap = cap_edg & (cap_cnt_ff == CAP_LAST);

  // Status and read data; unused status bits stay zero.
  wire [7:0] stat_val = (8'(done_ff) << STAT_DONE) |
                        (8'(write_collision_flag_ff) << STAT_WRITE_COLLISION_FLAG) |
                        (8'(mode_fault_flag_ff) << STAT_MODE_FAULT_FLAG);
  wire [7:0] rd_mux = hit_data ? rx_buf_ff :
                      hit_ctrl ? ctrl_ff   :
                      hit_stat ? stat_val  : BYTE_RESET;

  // Flag clear sequences; a new event always wins over its clear.
  wire nxt_done = last_cap | (done_ff & ~(done_arm_ff & dr_access));
  wire nxt_write_collision_flag = write_collision_flag_evt | (write_collision_flag_ff & ~(write_collision_flag_arm_ff & dr_access));
  wire nxt_mode_fault_flag = fault_evt | (mode_fault_flag_ff & ~(mode_fault_flag_arm_ff & cr_write));

  // Control register next value.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (cr_write) begin
      nxt_ctrl = pwdata[7:0];
      // Enabling is refused under a fault unless the sequence is armed.
      if (mode_fault_flag_ff & ~mode_fault_flag_arm_ff) begin
        nxt_ctrl[CTL_PORT_EN] = 1'b0;
        nxt_ctrl[CTL_MASTER]  = 1'b0;
      end
    end
    // A master fault takes the port off the pins and into slave mode.
    if (fault_evt) begin
      nxt_ctrl[CTL_PORT_EN] = 1'b0;
      nxt_ctrl[CTL_MASTER]  = 1'b0;
    end
  end

  // Transfer engine next state.
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_out   = out_bit_ff;
    nxt_edge  = edge_cnt_ff;
    nxt_cap   = cap_cnt_ff;
    nxt_div   = div_cnt_ff;
    nxt_rx    = rx_buf_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // Counters rest at zero between bytes.
        nxt_edge = 5'h00;
        nxt_cap  = 3'h0;
        nxt_div  = 7'h00;
        if (dr_load) begin
          // The written byte goes straight into the shifter.
          nxt_shift = pwdata[7:0];
          nxt_out   = pwdata[BYTE_MSB];
          if (master_on) begin
            nxt_state = ST_MASTER;
          end
        end else if (slave_sel) begin
          nxt_state = ST_SLAVE;
        end
      end
      ST_MASTER: begin
        // Disabling or a fault abandons the byte.
        if (!master_on) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_div = m_tick ? 7'h00 : div_cnt_ff + 7'h01;
        end
      end
      ST_SLAVE: begin
        // Select going high ends the slave frame.
        if (!slave_sel) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    // Serial clock edge: capture or drive, then count.
    if (sh_edge) begin
      nxt_edge = edge_cnt_ff + 5'h01;
      if (cap_edg) begin
        nxt_shift = shifted;
        nxt_cap   = cap_cnt_ff + 3'h1;
        if (last_cap) begin
          nxt_rx = shifted;
        end
      end else begin
        nxt_out = shift_ff[BYTE_MSB];
      end
      if (edge_cnt_ff == EDGE_LAST) begin
        nxt_edge = 5'h00;
        nxt_cap  = 3'h0;
        if (state_ff == ST_MASTER) begin
          nxt_state = ST_IDLE;
        end
      end
    end
  end

  // Master clock toggles on each tick and rests at the polarity level.
  assign nxt_sck = (state_ff == ST_MASTER && master_on) ?
                   (sck_ff ^ m_tick) : clock_polarity;

  // Bus answer registers: zero wait state, data sampled in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= setup ? {24'h00_0000, rd_mux} : prdata_ff;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
    end
  end

  // Control register and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= CTRL_RESET;
      done_ff     <= 1'b0;
      write_collision_flag_ff     <= 1'b0;
      mode_fault_flag_ff     <= 1'b0;
      done_arm_ff <= 1'b0;
      write_collision_flag_arm_ff <= 1'b0;
      mode_fault_flag_arm_ff <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      done_ff     <= nxt_done;
      write_collision_flag_ff     <= nxt_write_collision_flag;
      mode_fault_flag_ff     <= nxt_mode_fault_flag;
      done_arm_ff <= nxt_done & ~dr_access & (done_arm_ff | sr_access);
      write_collision_flag_arm_ff <= nxt_write_collision_flag & ~dr_access & (write_collision_flag_arm_ff | sr_access);
      mode_fault_flag_arm_ff <= nxt_mode_fault_flag & ~cr_write & (mode_fault_flag_arm_ff | sr_access);
    end
  end

  // Transfer engine registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= ST_IDLE;
      shift_ff    <= BYTE_RESET;
      out_bit_ff  <= 1'b0;
      edge_cnt_ff <= 5'h00;
      cap_cnt_ff  <= 3'h0;
      div_cnt_ff  <= 7'h00;
      rx_buf_ff   <= BYTE_RESET;
      sck_ff      <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      shift_ff    <= nxt_shift;
      out_bit_ff  <= nxt_out;
      edge_cnt_ff <= nxt_edge;
      cap_cnt_ff  <= nxt_cap;
      div_cnt_ff  <= nxt_div;
      rx_buf_ff   <= nxt_rx;
      sck_ff      <= nxt_sck;
      sck_prev_ff <= sck_in;
    end
  end

  // Pin enables and interrupt request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_oe_ff  <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      sck_oe_ff  <= master_on;
      mosi_oe_ff <= master_on;
      miso_oe_ff <= slave_sel;
      irq_ff     <= ctrl_ff[CTL_IRQ_EN] & (done_ff | mode_fault_flag_ff);
    end
  end

  // Outputs come straight from flip-flops.
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign sck_out  = sck_ff;
  assign sck_oe   = sck_oe_ff;
  assign mosi_out = out_bit_ff;
  assign mosi_oe  = mosi_oe_ff;
  assign miso_out = out_bit_ff;
  assign miso_oe  = miso_oe_ff;
  assign irq      = irq_ff;

  // The request follows an enabled done flag one cycle later.
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[CTL_IRQ_EN] && (done_ff || mode_fault_flag_ff) |=> irq_ff)
    else $error("interrupt not raised for enabled flag");

  // Without the port enable no pin is driven.
  pins_port_a: assert property (@(posedge pclk) disable iff (!presetn)
    !port_en |=> !sck_oe && !mosi_oe && !miso_oe)
    else $error("pin driven while port disabled");

  // A fault drops enable and master select and raises the flag.
  fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_evt |=> !ctrl_ff[CTL_PORT_EN] && !ctrl_ff[CTL_MASTER] && mode_fault_flag_ff)
    else $error("mode fault not handled");

  // The clock rests at the polarity level outside a master byte.
  idle_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff != ST_MASTER |=> sck_ff == $past(clock_polarity))
    else $error("clock not at idle level");

  // A refused data write does not start a transfer.
  done_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data && done_ff && !done_arm_ff && state_ff == ST_IDLE && !slave_sel
    |=> state_ff == ST_IDLE)
    else $error("data write accepted while done set");

  // A write during a transfer sets the collision flag and keeps going.
  write_collision_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_collision_flag_evt && state_ff == ST_MASTER && !sh_edge && master_on
    |=> write_collision_flag_ff && state_ff == ST_MASTER && $stable(shift_ff))
    else $error("collision mishandled");

  // The last capture fills the buffer and sets the done flag.
  rx_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    last_cap |=> done_ff && rx_buf_ff == $past(shifted))
    else $error("receive buffer not loaded");

  // Status reads show zero in unused positions.
  stat_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff && hit_stat |-> prdata_ff[31:8] == 24'h00_0000 &&
    prdata_ff[5] == 1'b0 && prdata_ff[3:0] == 4'h0)
    else $error("unused status bits not zero");

  // Master ticks never fall on two cycles in a row.
  rate_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    m_tick |=> !m_tick)
    else $error("master clock too fast");

endmodule
`default_nettype wire

// file: spi_far_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side slave model that answers the port byte for byte.
module spi_far_slave (
  input  wire logic       sck,     // Serial clock seen on the wire.
  input  wire logic       mosi,    // Data from the master.
  input  wire logic       sel,     // High while this slave is framed.
  input  wire logic       clock_polarity,    // Idle clock level in use.
  input  wire logic       clock_phase,    // Clock phase in use.
  input  wire logic [7:0] reply,   // Byte sent back to the master.
  output logic            miso,    // Data to the master.
  output logic      [7:0] rx_byte  // Byte taken from the master.
);
  logic [7:0] tx = 8'h00;  // Outgoing shifter.
  logic       lead;        // High on the edge that leaves the idle level.
  initial miso = 1'b0;
  // Opening a frame loads the reply; phase zero needs the MSB at once.
  always @(posedge sel) begin
    tx = reply;
    rx_byte = 8'h00;
    if (!clock_phase) begin
      miso = reply[7];
    end
  end
  // A released line shows the inverse of its last bit, never a stale one.
  always @(negedge sel) begin
    miso = ~miso;
  end
  // Each clock edge either captures or shifts, MSB first.
  always @(sck) begin
    lead = (sck != clock_polarity);
    if (sel && (lead ^ clock_phase)) begin
      rx_byte = {rx_byte[6:0], mosi};
    end else if (sel && clock_phase) begin
      miso = tx[7];
      tx = tx << 1;
    end else if (sel) begin
      tx = tx << 1;
      miso = tx[7];
    end
  end
endmodule
`default_nettype wire

// file: spi_master_slave_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: bus master, far-side slave and an external master.
module spi_master_slave_port_tb_top;
  import spi_port_pkg::*;
  logic        pclk;                  // Bus clock, 100 MHz.
  logic        presetn      = 1'b0;   // Reset, active low.
  logic        psel         = 1'b0;   // Bus select.
  logic        penable      = 1'b0;   // Bus access phase.
  logic        pwrite       = 1'b0;   // Bus direction.
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0;
  logic [31:0] prdata, rd;            // Read data on the bus and as taken.
  logic        pready, pslverr, last_err;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
  logic        ss_n_in      = 1'b1;   // Select into the port, active low.
  logic        tb_sck       = 1'b0;   // Clock from the bench as master.
  logic        tb_mosi      = 1'b0;   // Data from the bench as master.
  logic        far_sel      = 1'b0;   // Frame for the far-side slave.
  logic        far_miso, clock_polarity, clock_phase;
  logic [7:0]  reply, tx, ctl, got, far_rx;
  logic [7:0]  exp_q[$];              // Bytes the port should receive.
  int          err_count    = 0;
  int          total_checks = 0;
  int          n;
  int          c0;                    // Cycle count when a byte was written.
  int          cyc          = 0;      // Bus clock edges since the start.
  int          divs[6]      = '{4, 8, 16, 32, 64, 128};
  logic [2:0]  codes[6]     = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  // Each wire takes the level of whichever party drives it.
  wire logic   sck_w        = sck_oe ? sck_out : tb_sck;
  wire logic   mosi_w       = mosi_oe ? mosi_out : tb_mosi;
  wire logic   miso_w       = miso_oe ? miso_out : far_miso;

  spi_port dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w),
    .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in,
    .irq
  );

  spi_far_slave far (
    .sck(sck_w), .mosi(mosi_w), .sel(far_sel), .clock_polarity, .clock_phase, .reply,
    .miso(far_miso), .rx_byte(far_rx)
  );

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout();
    chk("wait bound", 32'h0, 32'h1);
    results();
  endtask

  // One bus transfer: setup, then access until the slave is ready.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) timeout();
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts bus cycles until the interrupt request rises.
  task automatic wait_irq(output int cnt);
    for (cnt = 0; cnt < 3000; cnt++) begin
      @(posedge pclk);
      if (irq === 1'b1) break;
    end
    if (cnt == 3000) timeout();
  endtask

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts bus clock edges for the byte timing check.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  // Main sequence.
  initial begin
    void'($urandom(54));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only status and an unmapped place.
    apb(0, ADDR_STAT, 8'h00, rd);
    chk("status reset", rd, 32'h0);
    apb(0, ADDR_CTRL, 8'h00, rd);
    chk("control reset", rd, 32'h0);
    chk("pins released", 32'({sck_oe, mosi_oe, miso_oe}), 32'h0);
    apb(1, ADDR_STAT, 8'hFF, rd);
    apb(0, ADDR_STAT, 8'h00, rd);
    chk("status write", rd, 32'h0);
    apb(1, 12'h090, 8'h5A, rd);
    chk("unmapped", 32'(last_err), 32'h1);
    $display("test registers done");
    // Master bytes at every rate, random polarity and phase.
    for (int i = 0; i < 6; i++) begin
      clock_polarity = 1'($urandom);
      clock_phase = 1'($urandom);
      ctl = {2'b11, codes[i][2], 1'b1, clock_polarity, clock_phase, codes[i][1:0]};
      apb(1, ADDR_CTRL, ctl, rd);
      repeat (2) @(posedge pclk);
      chk("sck idle", 32'(sck_out), 32'(clock_polarity));
      chk("master pins", 32'({sck_oe, mosi_oe}), 32'h3);
      reply = 8'($urandom);
      tx = 8'($urandom);
      exp_q.push_back(reply);
      far_sel <= 1'b1;
      apb(1, ADDR_DATA, tx, rd);
      c0 = cyc;
      if (i == 0) apb(1, ADDR_DATA, ~tx, rd);
      wait_irq(n);
      // The last capture falls (15 + phase) half periods after the write.
      n = cyc - c0 - (15 + int'(clock_phase)) * divs[i] / 2;
      chk("byte time", 32'(n >= 0 && n <= 4), 32'h1);
      // Phase zero still has a closing clock edge; let it pass first.
      repeat (divs[i]) @(posedge pclk);
      far_sel <= 1'b0;
      chk("far rx", 32'(far_rx), 32'(tx));
      apb(1, ADDR_DATA, 8'h3C, rd);
      apb(0, ADDR_STAT, 8'h00, rd);
      chk("status done", rd, i == 0 ? 32'hC0 : 32'h80);
      apb(0, ADDR_DATA, 8'h00, rd);
      chk("rx buffer", rd, 32'(exp_q.pop_front()));
      apb(0, ADDR_STAT, 8'h00, rd);
      chk("status clear", rd, 32'h0);
      chk("irq clear", 32'(irq), 32'h0);
      chk("sck still", 32'(sck_out), 32'(clock_polarity));
    end
    $display("test master done");
    // Select pulled low while master: fault, then the clearing sequence.
    apb(1, ADDR_CTRL, 8'h50, rd);
    ss_n_in <= 1'b0;
    repeat (3) @(posedge pclk);
    ss_n_in <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("masked irq", 32'(irq), 32'h0);
    apb(1, ADDR_CTRL, 8'hD0, rd);
    apb(0, ADDR_CTRL, 8'h00, rd);
    chk("ctrl after fault", rd, 32'h80);
    chk("fault irq", 32'(irq), 32'h1);
    apb(0, ADDR_STAT, 8'h00, rd);
    chk("fault flag", rd, 32'h10);
    apb(1, ADDR_CTRL, 8'h50, rd);
    apb(0, ADDR_STAT, 8'h00, rd);
    chk("fault cleared", rd, 32'h0);
    apb(0, ADDR_CTRL, 8'h00, rd);
    chk("ctrl restored", rd, 32'h50);
    $display("test fault done");
    // Slave byte, phase one, rate bits random, one frozen write.
    ctl = {6'h11, 2'($urandom)};
    apb(1, ADDR_CTRL, ctl, rd);
    tx = 8'($urandom);
    reply = 8'($urandom);
    apb(1, ADDR_DATA, tx, rd);
    ss_n_in <= 1'b0;
    apb(1, ADDR_DATA, 8'h00, rd);
    for (int b = 7; b >= 0; b--) begin
      repeat (4) @(posedge pclk);
      tb_sck <= 1'b1;
      tb_mosi <= reply[b];
      repeat (4) @(posedge pclk);
      tb_sck <= 1'b0;
      got[b] = miso_w;
    end
    repeat (4) @(posedge pclk);
    chk("slave pins", 32'({sck_oe, mosi_oe, miso_oe}), 32'h1);
    ss_n_in <= 1'b1;
    apb(0, ADDR_STAT, 8'h00, rd);
    chk("slave status", rd, 32'hC0);
    apb(0, ADDR_DATA, 8'h00, rd);
    chk("slave rx", rd, 32'(reply));
    chk("slave tx", 32'(got), 32'(tx));
    $display("test slave done");
    results();
  end
endmodule
`default_nettype wire
